/* File: serial_host_register_port.sv */
// four-wire serial host port giving register and fifo access
`timescale 1ns/1ps

// Functional notes
// - straps are sampled only during reset; serial or no host interface decoded
// - four lines: shift clock, data in, data out, active-low chip select
// - chip select falling restarts the sequence; next byte is a header
// - data in sampled on clock rise, data out changes on clock fall
// - transfers are bytes, most significant bit first, both directions
// - first byte is the header; its code governs until chip select rises
// - 40h alternating, 48h interleaved alternating, 43h constant-address burst
// - 41h read then write burst, 49h its interleaved variant
// - header bit 2 selects the upper register page 80h to FFh
// - write address takes one data byte; read address gets one read slot
// - non-interleaved alternating mode never drives out while receiving
// - interleaved: read data goes out while the next address comes in
// - constant address: fifo addresses hit current location, pointer steps each byte
// - constant address: one address, then continuous writes or reads
// - interrupt output active low after reset, high when configured, any time
// - read-then-write: a write address ends reads; rest is data to it
module serial_host_register_port (
  // clock and reset
  input logic clk_sys_i,
  input logic sys_rst_i,
  // interface selection straps
  input serial_host_pkg::strap_t strap_i,
  output logic serial_sel_o,
  output logic no_host_if_o,
  // serial host port
  input logic serial_clk_i,
  input logic serial_cs_n_i,
  input logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // register space
  output serial_host_pkg::reg_req_t reg_req_o,
  input logic [7:0] reg_rdata_i,
  // interrupt request
  input logic int_req_i,
  input logic int_active_high_i,
  output logic irq_o
);

  typedef struct packed {
    logic serial_en;
    logic none_sel;
    logic sck_q;
    logic cs_n_q;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] rd_buf;
    logic dout;
    logic oe;
    logic tx_arm;
    serial_host_pkg::seq_phase_t phase;
    serial_host_pkg::seq_mode_t mode;
    logic page;
    logic [1:0] rd_cnt;
    serial_host_pkg::reg_req_t req;
    logic int_pol;
    logic irq;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] hdr_base;
  logic interleaved;
  logic burst_on_write;
  logic [7:0] next_addr;

  // fifo window reached through constant-address bursts
  function automatic logic is_fifo_addr(input logic [7:0] a);
    is_fifo_addr = (a <= serial_host_pkg::FIFO_LOW_LAST) ||
                   (a == serial_host_pkg::FIFO_ALT_A) ||
                   (a == serial_host_pkg::FIFO_ALT_B);
  endfunction

  // edge detection; inputs are synchronous to the system clock
  assign sck_rise = st.serial_en && !serial_cs_n_i && serial_clk_i && !st.sck_q;
  assign sck_fall = st.serial_en && !serial_cs_n_i && !serial_clk_i && st.sck_q;
  assign cs_fall = st.serial_en && st.cs_n_q && !serial_cs_n_i;
  assign byte_done = sck_rise && (st.bit_cnt == serial_host_pkg::BIT_LAST);
  assign rx_byte = {st.rx_sh, serial_data_in_i};
  assign hdr_base = rx_byte & ~serial_host_pkg::HDR_PAGE_MASK;
  assign interleaved = (st.mode == serial_host_pkg::MODE_ALT_IL) ||
                       (st.mode == serial_host_pkg::MODE_RW_IL);
  assign burst_on_write = (st.mode == serial_host_pkg::MODE_RW_NI) ||
                          (st.mode == serial_host_pkg::MODE_RW_IL);
  assign next_addr = {st.page, rx_byte[6:0]};

  // next state: bit engine, sequence decoder, read pipeline, interrupt polarity
  always_comb
  begin
    next_st = st;
    next_st.sck_q = serial_clk_i;
    next_st.cs_n_q = serial_cs_n_i;
    next_st.req.wr = 1'b0;
    next_st.req.fifo_step = 1'b0;
    // strobe fires as the wait count drops from one to zero; bursts wait a cycle longer for the step
    next_st.req.rd = (st.rd_cnt == serial_host_pkg::RD_ISSUE);
    // read pipeline: strobe one cycle, capture the answer in that cycle
    if (st.rd_cnt != 2'h0)
    begin
      next_st.rd_cnt = st.rd_cnt - 2'h1;
    end
    if (st.req.rd)
    begin
      next_st.rd_buf = reg_rdata_i;
    end
    // shift in on the rising edge, msb first
    if (sck_rise)
    begin
      next_st.rx_sh = rx_byte[6:0];
      next_st.bit_cnt = st.bit_cnt + 3'h1;
    end
    // shift out on the falling edge; a new byte loads from the read buffer
    if (sck_fall)
    begin
      if (st.bit_cnt == 3'h0)
      begin
        next_st.oe = st.tx_arm;
        next_st.dout = st.rd_buf[7];
        next_st.tx_sh = {st.rd_buf[6:0], 1'b0};
      end
      else
      begin
        next_st.dout = st.tx_sh[7];
        next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
      end
    end
    // a complete byte steers the sequence
    if (byte_done)
    begin
      unique case (st.phase)
        serial_host_pkg::PH_HDR:
        begin
          next_st.page = rx_byte[serial_host_pkg::HDR_PAGE_BIT];
          next_st.phase = serial_host_pkg::PH_ADDR;
          // unknown headers leave the port deaf until chip select rises
          if (hdr_base == serial_host_pkg::HDR_ALT_NI)
            next_st.mode = serial_host_pkg::MODE_ALT_NI;
          else if (hdr_base == serial_host_pkg::HDR_ALT_IL)
            next_st.mode = serial_host_pkg::MODE_ALT_IL;
          else if (hdr_base == serial_host_pkg::HDR_CONST)
            next_st.mode = serial_host_pkg::MODE_CONST;
          else if (hdr_base == serial_host_pkg::HDR_RW_NI)
            next_st.mode = serial_host_pkg::MODE_RW_NI;
          else if (hdr_base == serial_host_pkg::HDR_RW_IL)
            next_st.mode = serial_host_pkg::MODE_RW_IL;
          else
            next_st.phase = serial_host_pkg::PH_IGNORE;
        end
        serial_host_pkg::PH_ADDR:
        begin
          next_st.req.addr = next_addr;
          next_st.req.fifo_sel = (st.mode == serial_host_pkg::MODE_CONST) &&
                                 is_fifo_addr(next_addr);
          next_st.tx_arm = rx_byte[serial_host_pkg::ADR_READ_BIT];
          if (rx_byte[serial_host_pkg::ADR_READ_BIT])
          begin
            next_st.rd_cnt = serial_host_pkg::RD_WAIT_PLAIN;
            if (st.mode == serial_host_pkg::MODE_CONST)
              next_st.phase = serial_host_pkg::PH_BURST_R;
            else if (interleaved)
              next_st.phase = serial_host_pkg::PH_ADDR;
            else
              next_st.phase = serial_host_pkg::PH_RSLOT;
          end
          else if ((st.mode == serial_host_pkg::MODE_CONST) || burst_on_write)
          begin
            next_st.phase = serial_host_pkg::PH_BURST_W;
          end
          else
          begin
            next_st.phase = serial_host_pkg::PH_WDATA;
          end
        end
        serial_host_pkg::PH_WDATA:
        begin
          next_st.req.wdata = rx_byte;
          next_st.req.wr = 1'b1;
          next_st.phase = serial_host_pkg::PH_ADDR;
        end
        serial_host_pkg::PH_RSLOT:
        begin
          // bits heard during a read slot are ignored
          next_st.tx_arm = 1'b0;
          next_st.phase = serial_host_pkg::PH_ADDR;
        end
        serial_host_pkg::PH_BURST_W:
        begin
          next_st.req.wdata = rx_byte;
          next_st.req.wr = 1'b1;
          next_st.req.fifo_step = st.req.fifo_sel;
        end
        serial_host_pkg::PH_BURST_R:
        begin
          // step the pointer first, then fetch the following location
          next_st.req.fifo_step = st.req.fifo_sel;
          next_st.rd_cnt = serial_host_pkg::RD_WAIT_STEP;
        end
        serial_host_pkg::PH_IGNORE:
        begin
          next_st.phase = serial_host_pkg::PH_IGNORE;
        end
        default:
        begin
          next_st.phase = serial_host_pkg::PH_IGNORE;
        end
      endcase
    end
    // chip select edges restart or end the sequence and free the line
    if (cs_fall || serial_cs_n_i)
    begin
      next_st.bit_cnt = 3'h0;
      next_st.phase = serial_host_pkg::PH_HDR;
      next_st.tx_arm = 1'b0;
      next_st.oe = 1'b0;
    end
    // interrupt polarity follows its configuration, request passes any time
    next_st.int_pol = int_active_high_i;
    next_st.irq = st.int_pol ? int_req_i : !int_req_i;
    // synchronous reset; straps are caught while reset is held
    if (sys_rst_i)
    begin
      next_st = '0;
      next_st.sck_q = 1'b0;
      next_st.cs_n_q = 1'b1;
      next_st.phase = serial_host_pkg::PH_HDR;
      next_st.mode = serial_host_pkg::MODE_ALT_NI;
      next_st.req = serial_host_pkg::REQ_RESET;
      next_st.int_pol = 1'b0;
      next_st.irq = 1'b1;
      next_st.serial_en = !strap_i.wr_n && !strap_i.rd_n && strap_i.cs_n &&
                          !strap_i.ale;
      next_st.none_sel = !strap_i.wr_n && !strap_i.rd_n && !strap_i.cs_n &&
                         !strap_i.ale;
    end
  end

  // single state register
  always_ff @(posedge clk_sys_i)
  begin
    st <= next_st;
  end

  // outputs straight from state
  assign serial_sel_o = st.serial_en;
  assign no_host_if_o = st.none_sel;
  assign serial_data_out_o = st.dout;
  assign serial_data_out_oe_o = st.oe;
  assign reg_req_o = st.req;
  assign irq_o = st.irq;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // restart, release, output timing and header decode on the link

  a_cs_restart: assert property (cs_fall |=> st.phase == serial_host_pkg::PH_HDR && st.bit_cnt == 3'h0)
    else $error("chip select fall did not restart the sequence");
  a_cs_release: assert property (serial_cs_n_i |=> !serial_data_out_oe_o && st.phase == serial_host_pkg::PH_HDR)
    else $error("line driven or sequence alive with chip select high");
  a_out_on_fall: assert property ($changed(serial_data_out_o) |-> $past(sck_fall))
    else $error("data out changed outside a clock fall");
  a_hdr_decode: assert property (byte_done && st.phase == serial_host_pkg::PH_HDR && hdr_base == serial_host_pkg::HDR_ALT_IL |=> st.mode == serial_host_pkg::MODE_ALT_IL && st.phase == serial_host_pkg::PH_ADDR)
    else $error("interleaved header not decoded");
  a_page_pick: assert property (byte_done && st.phase == serial_host_pkg::PH_HDR |=> st.page == $past(serial_data_in_i ? st.rx_sh[1] : st.rx_sh[1]))
    else $error("page bit not taken from header");
  a_ni_quiet: assert property (st.mode == serial_host_pkg::MODE_ALT_NI && st.phase == serial_host_pkg::PH_ADDR && st.bit_cnt != 3'h0 |-> !serial_data_out_oe_o)
    else $error("driven while receiving in non-interleaved mode");
  // read pipeline: strobe two cycles after the address, data caught on the strobe
  a_rd_fetch: assert property (byte_done && st.phase == serial_host_pkg::PH_ADDR &&
    st.rx_sh[6] |=> ##1 reg_req_o.rd ##1 st.rd_buf == $past(reg_rdata_i))
    else $error("read address did not fetch data");
  a_rd_once: assert property (reg_req_o.rd |=> !reg_req_o.rd)
    else $error("read strobe longer than one cycle");
  a_wr_once: assert property (reg_req_o.wr |=> !reg_req_o.wr)
    else $error("write strobe longer than one cycle");
  a_burst_step: assert property (byte_done && st.phase == serial_host_pkg::PH_BURST_R &&
    st.req.fifo_sel |=> reg_req_o.fifo_step && !reg_req_o.rd ##1 !reg_req_o.rd ##1 reg_req_o.rd)
    else $error("fifo step not followed by next read");
  a_step_gate: assert property (reg_req_o.fifo_step |-> reg_req_o.fifo_sel)
    else $error("fifo step outside a fifo address");
  a_rw_lock: assert property (byte_done && burst_on_write && st.phase == serial_host_pkg::PH_ADDR && !st.rx_sh[6] |=> st.phase == serial_host_pkg::PH_BURST_W)
    else $error("write address did not end the read phase");
  // interrupt pin follows request and polarity, unrelated to the link
  a_irq_pol: assert property (1'b1 |=> irq_o == ($past(st.int_pol) ? $past(int_req_i) : !$past(int_req_i)))
    else $error("interrupt polarity wrong");

  // main sequences worth seeing at least once
  c_const_read: cover property (byte_done && st.phase == serial_host_pkg::PH_BURST_R);
  c_il_read: cover property (serial_data_out_oe_o && st.mode == serial_host_pkg::MODE_ALT_IL && st.bit_cnt != 3'h0);
  c_rw_burst: cover property (reg_req_o.wr && st.mode == serial_host_pkg::MODE_RW_NI);
  c_upper_page: cover property (reg_req_o.wr && reg_req_o.addr[7]);
  c_rw_il: cover property (reg_req_o.wr && st.mode == serial_host_pkg::MODE_RW_IL);

endmodule // serial_host_register_port

/* File: serial_host_pkg.sv */
// constants, types and carriers for the serial host register port
package serial_host_pkg;

  // header byte codes (lower page), page select bit in the header
  localparam logic [7:0] HDR_ALT_NI = 8'h40;
  localparam logic [7:0] HDR_ALT_IL = 8'h48;
  localparam logic [7:0] HDR_CONST = 8'h43;
  localparam logic [7:0] HDR_RW_NI = 8'h41;
  localparam logic [7:0] HDR_RW_IL = 8'h49;
  localparam int HDR_PAGE_BIT = 2;
  localparam logic [7:0] HDR_PAGE_MASK = 8'h04;

  // address byte layout: top bit marks a read, low seven bits the offset
  localparam int ADR_READ_BIT = 7;

  // addresses that reach the current fifo location in constant-address mode
  localparam logic [7:0] FIFO_LOW_LAST = 8'h1F;
  localparam logic [7:0] FIFO_ALT_A = 8'h6A;
  localparam logic [7:0] FIFO_ALT_B = 8'h7A;

  // bit counter and read pipeline timing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] RD_WAIT_PLAIN = 2'h1;
  localparam logic [1:0] RD_WAIT_STEP = 2'h2;
  localparam logic [1:0] RD_ISSUE = 2'h1;

  // access sequence chosen by the header
  typedef enum logic [2:0] {
    MODE_ALT_NI = 3'b000,
    MODE_ALT_IL = 3'b001,
    MODE_CONST = 3'b011,
    MODE_RW_NI = 3'b010,
    MODE_RW_IL = 3'b110
  } seq_mode_t;

  // byte phase within a sequence, gray along header, address, data
  typedef enum logic [2:0] {
    PH_HDR = 3'b000,
    PH_ADDR = 3'b001,
    PH_WDATA = 3'b011,
    PH_RSLOT = 3'b010,
    PH_BURST_W = 3'b110,
    PH_BURST_R = 3'b111,
    PH_IGNORE = 3'b100
  } seq_phase_t;

  // host interface selection straps
  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic cs_n;
    logic ale;
  } strap_t;

  // register side request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic fifo_sel;
    logic fifo_step;
  } reg_req_t;

  localparam reg_req_t REQ_RESET = '{8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

/* File: serial_host_master.sv */
// host side shift-master model driving the serial register port
`timescale 1ns/1ps
module serial_host_master (
  // system clock, used only to pace the shift clock
  input logic clk_sys_i,
  // serial lines toward the device, kept as separate wires
  output logic serial_clk_o,
  output logic serial_cs_n_o,
  output logic serial_data_o,
  input logic serial_data_i,
  input logic serial_oe_i
);
  localparam int HALF = 5; // phase length, reads need at least four cycles
  logic drove;

  // idle: select high, shift clock low and standing still
  initial
  begin
    serial_clk_o = 1'b0;
    serial_cs_n_o = 1'b1;
    serial_data_o = 1'b1;
    drove = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // select falls with the shift clock idle
  task automatic frame_begin();
    wait_n(HALF);
    serial_cs_n_o = 1'b0;
    wait_n(HALF);
  endtask

  // one byte, msb first; data set while the clock is low, both sides sample at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    drove = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      serial_data_o = tx[i];
      wait_n(HALF);
      rx[i] = serial_data_i;
      drove = drove | serial_oe_i;
      serial_clk_o = 1'b1;
      wait_n(HALF);
      serial_clk_o = 1'b0;
    end
  endtask

  // released line shows the inverse of its last bit, never a stale copy
  task automatic frame_end();
    wait_n(HALF);
    serial_cs_n_o = 1'b1;
    serial_data_o = ~serial_data_o;
    wait_n(2 * HALF);
  endtask
endmodule // serial_host_master

/* File: tb_top.sv */
// self-checking testbench for the serial host register port
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i;
  logic sys_rst_i;
  serial_host_pkg::strap_t strap;
  serial_host_pkg::reg_req_t req;
  logic sclk, cs_n, sdi, sdo, sdo_oe, host_in, serial_sel, no_host, int_req, int_hi, irq;
  logic [7:0] rdata, fifo_ptr, rx, pg, a1, a2, a3, d, fa, base;
  logic [15:0] wrq[$];
  int miscompares, checks_done, steps, steps_before;

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction

  // register space model; fifo reads return the pointer
  assign rdata = (req.fifo_sel === 1'b1) ? fifo_ptr : exp_rd(req.addr);
  assign host_in = sdo_oe ? sdo : ~sdo; // released line never shows the last bit

  always @(posedge clk_sys_i)
  begin
    if (req.wr === 1'b1) wrq.push_back({req.addr, req.wdata});
    if (req.fifo_step === 1'b1)
    begin
      fifo_ptr <= fifo_ptr + 8'h01;
      steps++;
    end
  end

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  serial_host_register_port dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .strap_i(strap), .serial_sel_o(serial_sel), .no_host_if_o(no_host),
    .serial_clk_i(sclk), .serial_cs_n_i(cs_n), .serial_data_in_i(sdi),
    .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe), .reg_req_o(req),
    .reg_rdata_i(rdata), .int_req_i(int_req), .int_active_high_i(int_hi), .irq_o(irq));

  serial_host_master host_u (.clk_sys_i(clk_sys_i), .serial_clk_o(sclk),
    .serial_cs_n_o(cs_n), .serial_data_o(sdi), .serial_data_i(host_in),
    .serial_oe_i(sdo_oe));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic chk_wr(input logic [15:0] exp);
    chk("write", exp, (wrq.size() > 0) ? wrq.pop_front() : 16'hXXXX);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // straps flip after release, so late sampling would show
  task automatic do_reset(input serial_host_pkg::strap_t s);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b1;
    strap = s;
    repeat (6) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    strap = ~s;
    repeat (2) @(negedge clk_sys_i);
  endtask

  task automatic irq_step(input logic req_v, input logic hi_v, input logic exp);
    int_req = req_v;
    int_hi = hi_v;
    repeat (3) @(negedge clk_sys_i);
    chk("irq", {15'h0000, exp}, {15'h0000, irq});
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    strap = 4'h0;
    int_req = 1'b0;
    int_hi = 1'b0;
    fifo_ptr = 8'h00;
    miscompares = 0;
    checks_done = 0;
    steps = 0;
    void'($urandom(32'hFFE6));
    do_reset(4'h0);
    chk("no_host_if", 16'h0001, {15'h0000, no_host});
    do_reset(4'h2);
    chk("serial_sel", 16'h0001, {15'h0000, serial_sel});
    chk("irq reset", 16'h0001, {15'h0000, irq});
    irq_step(1'b1, 1'b0, 1'b0);
    irq_step(1'b1, 1'b1, 1'b1);
    irq_step(1'b0, 1'b1, 1'b0);
    irq_step(1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      pg = k[0] ? serial_host_pkg::HDR_PAGE_MASK : 8'h00;
      a1 = 8'($urandom_range(127));
      a2 = 8'($urandom_range(127));
      a3 = 8'($urandom_range(127));
      d = 8'($urandom);
      // alternating, ending on a lone address that must write nothing
      host_u.frame_begin();
      host_u.xfer(serial_host_pkg::HDR_ALT_NI | pg, rx);
      host_u.xfer({1'b0, a1[6:0]}, rx);
      host_u.xfer(d, rx);
      chk("oe in write", 16'h0000, {15'h0000, host_u.drove});
      host_u.xfer({1'b1, a2[6:0]}, rx);
      host_u.xfer(8'h00, rx);
      chk("read slot", {8'h00, exp_rd({pg[2], a2[6:0]})}, {8'h00, rx});
      host_u.xfer({1'b0, a3[6:0]}, rx);
      host_u.frame_end();
      chk_wr({pg[2], a1[6:0], d});
      chk("lone addr", 16'h0000, 16'(wrq.size()));
      chk("oe idle", 16'h0000, {15'h0000, sdo_oe});
      // interleaved: read data rides under the next address
      host_u.frame_begin();
      host_u.xfer(serial_host_pkg::HDR_ALT_IL | pg, rx);
      host_u.xfer({1'b1, a1[6:0]}, rx);
      host_u.xfer({1'b1, a2[6:0]}, rx);
      chk("il read", {8'h00, exp_rd({pg[2], a1[6:0]})}, {8'h00, rx});
      host_u.xfer({1'b0, a3[6:0]}, rx);
      chk("il read", {8'h00, exp_rd({pg[2], a2[6:0]})}, {8'h00, rx});
      host_u.xfer(d, rx);
      host_u.frame_end();
      chk_wr({pg[2], a3[6:0], d});
      // read then write burst, both variants
      host_u.frame_begin();
      host_u.xfer((k[1] ? serial_host_pkg::HDR_RW_IL : serial_host_pkg::HDR_RW_NI) | pg, rx);
      host_u.xfer({1'b1, a1[6:0]}, rx);
      host_u.xfer(k[1] ? {1'b0, a3[6:0]} : 8'h00, rx);
      chk("rw read", {8'h00, exp_rd({pg[2], a1[6:0]})}, {8'h00, rx});
      if (!k[1]) host_u.xfer({1'b0, a3[6:0]}, rx);
      host_u.xfer(d, rx);
      host_u.xfer(~d, rx);
      host_u.frame_end();
      chk_wr({pg[2], a3[6:0], d});
      chk_wr({pg[2], a3[6:0], ~d});
      // constant address fifo burst, write then read
      fa = (k == 1) ? serial_host_pkg::FIFO_ALT_A : (k == 2) ? serial_host_pkg::FIFO_ALT_B
        : (a1 & serial_host_pkg::FIFO_LOW_LAST);
      steps_before = steps;
      host_u.frame_begin();
      host_u.xfer(serial_host_pkg::HDR_CONST, rx);
      host_u.xfer({1'b0, fa[6:0]}, rx);
      for (int i = 0; i < 3; i++) host_u.xfer(d + 8'(i), rx);
      host_u.frame_end();
      chk("fifo steps", 16'h0003, 16'(steps - steps_before));
      for (int i = 0; i < 3; i++) chk_wr({fa, 8'(d + 8'(i))});
      base = fifo_ptr;
      host_u.frame_begin();
      host_u.xfer(serial_host_pkg::HDR_CONST, rx);
      host_u.xfer({1'b1, fa[6:0]}, rx);
      for (int i = 0; i < 3; i++)
      begin
        host_u.xfer(8'h00, rx);
        chk("fifo read", {8'h00, 8'(base + 8'(i))}, {8'h00, rx});
      end
      host_u.frame_end();
    end
    // unknown header leaves the rest of the access ignored
    host_u.frame_begin();
    host_u.xfer(8'h42, rx);
    host_u.xfer({1'b0, a1[6:0]}, rx);
    host_u.xfer(d, rx);
    host_u.frame_end();
    chk("bad header", 16'h0000, 16'(wrq.size()));
    end_sim();
  end

  // hang guard, far above the real run length
  initial
  begin
    repeat (90000) @(posedge clk_sys_i);
    miscompares++;
    end_sim();
  end
endmodule // tb_top
